// [ecb_pkg.sv]
// Constants for the extended display-controller control bank
`default_nettype none
package ecb_pkg;
  // Register indices
  localparam logic [7:0] IDX_TLOCK = 8'h35;
  localparam logic [7:0] IDX_STRAP1 = 8'h36;
  localparam logic [7:0] IDX_STRAP2 = 8'h37;
  localparam logic [7:0] IDX_KEY_LO = 8'h38;
  localparam logic [7:0] IDX_KEY_HI = 8'h39;
  localparam logic [7:0] IDX_MISC1 = 8'h3A;
  localparam logic [7:0] IDX_XPOS = 8'h3B;
  localparam logic [7:0] IDX_ILACE = 8'h3C;
  localparam logic [7:0] IDX_SYSCFG = 8'h40;
  localparam logic [7:0] IDX_BFLAG = 8'h41;
  localparam logic [7:0] IDX_SCAN = 8'h42;
  localparam logic [7:0] IDX_EXTM = 8'h43;
  localparam logic [7:0] IDX_LO_FIRST = 8'h2D;
  localparam logic [7:0] IDX_LO_LAST = 8'h3F;
  localparam logic [7:0] IDX_HI_FIRST = 8'h40;
  // Unlock keys
  localparam logic [7:0] KEY_LO_MASK = 8'hCC;
  localparam logic [7:0] KEY_LO_VAL = 8'h48;
  localparam logic [7:0] KEY_HI_MASK = 8'hE0;
  localparam logic [7:0] KEY_HI_VAL = 8'hA0;
  localparam logic [7:0] KEY_STRAP = 8'hA5;
  // Reset values, fixed read bits and read-only strap mask
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STRAP1 = 8'h00;
  localparam logic [7:0] RST_STRAP2 = 8'h0A;
  localparam logic [7:0] SYSCFG_FIXED = 8'h30;
  localparam logic [7:0] STRAP1_RO_MASK = 8'h03;
  // Field positions
  localparam int TL_VLOCK = 4;
  localparam int TL_HLOCK = 5;
  localparam int S1_BW = 7;
  localparam int S2_TEST = 1;
  localparam int S2_CS = 3;
  localparam int M1_REFEN = 2;
  localparam int M1_TOP = 3;
  localparam int M1_DEPTH = 4;
  localparam int M1_FONT = 5;
  localparam int M1_RBD = 7;
  localparam int SC_ENH = 0;
  localparam int MC_INTL = 5;
  localparam int EM_SW8 = 2;
  localparam int EM_HX2 = 7;
  // Clock edges after reset release before straps are taken
  localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage
`default_nettype wire

// [ecb_bank.sv]
// Extended display-controller control bank behind an index/data port
`default_nettype none
module ecb_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Indexed host port
  input wire logic index_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Strap pins
  input wire logic [15:0] pixel_data_bus,
  // Fields of neighbouring registers
  input wire logic vret_protect,
  input wire logic std_refresh_count,
  input wire logic [1:0] ext_sys2_cpu_base,
  input wire logic [1:0] ext_sys2_scr_width,
  input wire logic [5:0] ext_sys4_cpu_base,
  input wire logic transfer_pos_bit8,
  input wire logic transfer_pos_select,
  // Host access context
  input wire logic [3:0] host_addr_hi,
  input wire logic host_addr13,
  input wire logic block_write_req,
  // Address and timing protection
  output logic [5:0] cpu_addr_hi,
  output logic vt_lock_67,
  output logic vt_lock_rest,
  output logic ht_lock_0_5,
  output logic ht_lock_ext,
  // Memory configuration
  output logic [2:0] page_mode_sel,
  output logic [3:0] total_mem_mb,
  output logic [3:0] vram_mb,
  output logic block_write_en,
  output logic outputs_tristate,
  output logic internal_clocks,
  // Display controls
  output logic [1:0] refresh_count,
  output logic top_mem_32k,
  output logic top_mem_64k,
  output logic pixel_depth_select,
  output logic fast_font_write,
  output logic read_burst_disable,
  output logic [8:0] transfer_pos,
  output logic transfer_pos_use,
  output logic [7:0] interlace_offset,
  output logic interlace_select,
  output logic enhanced_access_enable,
  output logic screen_width_bit8,
  output logic horizontal_count_double
);

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] tlock;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] key_lo;
    logic [7:0] key_hi;
    logic [7:0] misc1;
    logic [7:0] xpos;
    logic [7:0] ilace;
    logic enh;
    logic [7:0] bflag;
    logic [7:0] scan;
    logic [7:0] extm;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [1:0] wait_cnt;
    logic strapped;
    logic [7:0] rdata;
    logic [5:0] cpu_addr_hi;
    logic vt67;
    logic vtrest;
    logic ht05;
    logic htext;
    logic [2:0] page;
    logic [3:0] total;
    logic [3:0] vram;
    logic bw_en;
    logic tri_all;
    logic int_clk;
    logic [1:0] refresh;
    logic top32;
    logic top64;
    logic depth;
    logic font;
    logic rbd;
    logic [8:0] xpos_out;
    logic xpos_use;
    logic [7:0] ilace_out;
    logic ilace_use;
    logic enh_out;
    logic sw8;
    logic hx2;
  } ecb_state_t;

  ecb_state_t st_r;
  ecb_state_t st_nxt;
  logic lo_open;
  logic hi_open;
  logic strap_open;

  // Index belongs to the first extended range
  function automatic logic in_lo(input logic [7:0] i);
    in_lo = (i >= ecb_pkg::IDX_LO_FIRST) && (i <= ecb_pkg::IDX_LO_LAST);
  endfunction

  // Index belongs to the second extended range
  function automatic logic in_hi(input logic [7:0] i);
    in_hi = (i >= ecb_pkg::IDX_HI_FIRST);
  endfunction

  // Key decode straight from the stored key bytes
  assign lo_open = (st_r.key_lo & ecb_pkg::KEY_LO_MASK) == ecb_pkg::KEY_LO_VAL;
  assign hi_open = (st_r.key_hi & ecb_pkg::KEY_HI_MASK) == ecb_pkg::KEY_HI_VAL;
  assign strap_open = st_r.key_hi == ecb_pkg::KEY_STRAP;

  // Next state: port, straps and all decoded outputs
  always_comb begin
    logic [7:0] rd;
    logic wr_ok;
    logic [5:0] base;
    logic [3:0] dram;
    st_nxt = st_r;
    rd = 8'h00;
    wr_ok = 1'b0;
    base = 6'h00;
    dram = 4'h0;
    // Pin synchroniser for the strap bus
    st_nxt.sync1 = pixel_data_bus;
    st_nxt.sync2 = st_r.sync1;
    if (index_we) begin
      st_nxt.idx = wdata;
    end
    // Key registers stay reachable, otherwise nothing could unlock
    if (st_r.idx == ecb_pkg::IDX_KEY_LO || st_r.idx == ecb_pkg::IDX_KEY_HI) begin
      wr_ok = 1'b1;
    end else if (in_lo(st_r.idx)) begin
      wr_ok = lo_open;
    end else if (in_hi(st_r.idx)) begin
      wr_ok = hi_open;
    end
    // Read mux; locked or empty indices answer zero
    case (st_r.idx)
      ecb_pkg::IDX_TLOCK: rd = st_r.tlock;
      ecb_pkg::IDX_STRAP1: rd = st_r.s1;
      ecb_pkg::IDX_STRAP2: rd = st_r.s2;
      ecb_pkg::IDX_KEY_LO: rd = st_r.key_lo;
      ecb_pkg::IDX_KEY_HI: rd = st_r.key_hi;
      ecb_pkg::IDX_MISC1: rd = st_r.misc1;
      ecb_pkg::IDX_XPOS: rd = st_r.xpos;
      ecb_pkg::IDX_ILACE: rd = st_r.ilace;
      ecb_pkg::IDX_SYSCFG: rd = ecb_pkg::SYSCFG_FIXED | {7'h00, st_r.enh};
      ecb_pkg::IDX_BFLAG: rd = st_r.bflag;
      ecb_pkg::IDX_SCAN: rd = st_r.scan;
      ecb_pkg::IDX_EXTM: rd = st_r.extm;
      default: rd = 8'h00;
    endcase
    st_nxt.rdata = wr_ok ? rd : 8'h00;
    // Register writes; a bad key simply overwrites the good one
    if (data_we && wr_ok) begin
      case (st_r.idx)
        ecb_pkg::IDX_TLOCK: st_nxt.tlock = wdata;
        ecb_pkg::IDX_STRAP1: begin
          if (strap_open) begin
            st_nxt.s1 = (wdata & ~ecb_pkg::STRAP1_RO_MASK) |
                        (st_r.s1 & ecb_pkg::STRAP1_RO_MASK);
          end
        end
        ecb_pkg::IDX_STRAP2: begin
          if (strap_open) begin
            st_nxt.s2 = wdata;
          end
        end
        ecb_pkg::IDX_KEY_LO: st_nxt.key_lo = wdata;
        ecb_pkg::IDX_KEY_HI: st_nxt.key_hi = wdata;
        ecb_pkg::IDX_MISC1: st_nxt.misc1 = wdata;
        ecb_pkg::IDX_XPOS: st_nxt.xpos = wdata;
        ecb_pkg::IDX_ILACE: st_nxt.ilace = wdata;
        ecb_pkg::IDX_SYSCFG: st_nxt.enh = wdata[ecb_pkg::SC_ENH];
        ecb_pkg::IDX_BFLAG: st_nxt.bflag = wdata;
        ecb_pkg::IDX_SCAN: st_nxt.scan = wdata;
        ecb_pkg::IDX_EXTM: st_nxt.extm = wdata;
        default: ;
      endcase
    end
    // Straps taken once the synchroniser holds post-reset pin levels
    if (!st_r.strapped) begin
      if (st_r.wait_cnt == ecb_pkg::STRAP_WAIT) begin
        st_nxt.s1 = st_r.sync2[7:0];
        st_nxt.s2 = st_r.sync2[15:8];
        st_nxt.strapped = 1'b1;
      end else begin
        st_nxt.wait_cnt = st_r.wait_cnt + 2'h1;
      end
    end
    // CPU window base
    if (ext_sys4_cpu_base != 6'h00) begin
      base = ext_sys4_cpu_base;
    end else begin
      base = {ext_sys2_cpu_base, st_r.tlock[3:0]};
    end
    st_nxt.cpu_addr_hi = base + {2'h0, host_addr_hi};
    // Timing write protection
    st_nxt.vtrest = st_r.tlock[ecb_pkg::TL_VLOCK];
    st_nxt.vt67 = st_r.tlock[ecb_pkg::TL_VLOCK] | vret_protect;
    st_nxt.ht05 = st_r.tlock[ecb_pkg::TL_HLOCK] | vret_protect;
    st_nxt.htext = st_r.tlock[ecb_pkg::TL_HLOCK];
    // Memory decodes; reserved page code selects nothing
    case (st_r.s1[3:2])
      2'h0: st_nxt.page = 3'h1;
      2'h2: st_nxt.page = 3'h2;
      2'h3: st_nxt.page = 3'h4;
      default: st_nxt.page = 3'h0;
    endcase
    st_nxt.total = {1'b0, st_r.s1[6:5], 1'b0} + 4'h2;
    case (st_r.s2[6:5])
      2'h1: dram = 4'h4;
      2'h2: dram = 4'h2;
      default: dram = 4'h0;
    endcase
    st_nxt.vram = st_nxt.total - dram;
    st_nxt.bw_en = st_r.s1[ecb_pkg::S1_BW] & block_write_req;
    st_nxt.tri_all = ~st_r.s2[ecb_pkg::S2_TEST];
    st_nxt.int_clk = st_r.s2[ecb_pkg::S2_CS];
    // Display controls
    if (st_r.misc1[ecb_pkg::M1_REFEN]) begin
      st_nxt.refresh = st_r.misc1[1:0];
    end else begin
      st_nxt.refresh = {1'b0, std_refresh_count};
    end
    st_nxt.top32 = st_r.misc1[ecb_pkg::M1_TOP] & ~host_addr13;
    st_nxt.top64 = st_r.misc1[ecb_pkg::M1_TOP] & host_addr13;
    st_nxt.depth = st_r.misc1[ecb_pkg::M1_DEPTH];
    st_nxt.font = st_r.misc1[ecb_pkg::M1_FONT];
    // Software sets the companion enable first; nothing checked here
    st_nxt.rbd = st_r.misc1[ecb_pkg::M1_RBD];
    st_nxt.xpos_out = {transfer_pos_bit8, st_r.xpos};
    st_nxt.xpos_use = transfer_pos_select;
    st_nxt.ilace_out = st_r.ilace;
    st_nxt.ilace_use = st_r.scan[ecb_pkg::MC_INTL];
    st_nxt.enh_out = st_r.enh;
    st_nxt.sw8 = st_r.extm[ecb_pkg::EM_SW8] & (ext_sys2_scr_width == 2'h0);
    st_nxt.hx2 = st_r.extm[ecb_pkg::EM_HX2];
    if (rst) begin
      st_nxt = '0;
      st_nxt.s1 = ecb_pkg::RST_STRAP1;
      st_nxt.s2 = ecb_pkg::RST_STRAP2;
      st_nxt.key_lo = ecb_pkg::RST_ZERO;
      st_nxt.key_hi = ecb_pkg::RST_ZERO;
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // Outputs come straight from the state flops
  assign rdata = st_r.rdata;
  assign cpu_addr_hi = st_r.cpu_addr_hi;
  assign vt_lock_67 = st_r.vt67;
  assign vt_lock_rest = st_r.vtrest;
  assign ht_lock_0_5 = st_r.ht05;
  assign ht_lock_ext = st_r.htext;
  assign page_mode_sel = st_r.page;
  assign total_mem_mb = st_r.total;
  assign vram_mb = st_r.vram;
  assign block_write_en = st_r.bw_en;
  assign outputs_tristate = st_r.tri_all;
  assign internal_clocks = st_r.int_clk;
  assign refresh_count = st_r.refresh;
  assign top_mem_32k = st_r.top32;
  assign top_mem_64k = st_r.top64;
  assign pixel_depth_select = st_r.depth;
  assign fast_font_write = st_r.font;
  assign read_burst_disable = st_r.rbd;
  assign transfer_pos = st_r.xpos_out;
  assign transfer_pos_use = st_r.xpos_use;
  assign interlace_offset = st_r.ilace_out;
  assign interlace_select = st_r.ilace_use;
  assign enhanced_access_enable = st_r.enh_out;
  assign screen_width_bit8 = st_r.sw8;
  assign horizontal_count_double = st_r.hx2;

  // Checks beside the logic
  default clocking ck @(posedge clk); endclocking
  default disable iff (rst);

  a_locked_write_hold: assert property (
    data_we && st_r.idx == ecb_pkg::IDX_MISC1 && !lo_open |=> $stable(st_r.misc1))
    else $error("locked write changed misc register");
  a_strap_guard: assert property (
    st_r.strapped && data_we && st_r.idx == ecb_pkg::IDX_STRAP2 && !strap_open
    |=> $stable(st_r.s2))
    else $error("strap register written without key");
  a_strap_ro_bits: assert property (
    st_r.strapped ##1 st_r.strapped |-> st_r.s1[1:0] == $past(st_r.s1[1:0]))
    else $error("read-only strap bits changed");
  a_strap_capture: assert property (
    !st_r.strapped && st_r.wait_cnt == ecb_pkg::STRAP_WAIT
    |=> st_r.strapped && {st_r.s2, st_r.s1} == $past(st_r.sync2))
    else $error("straps not captured from pin bus");
  // First edge after reset still shows reset outputs, so skip it
  a_base_override: assert property (
    !$past(rst) && $past(ext_sys4_cpu_base) != 6'h00 |->
    cpu_addr_hi == $past(ext_sys4_cpu_base) + {2'h0, $past(host_addr_hi)})
    else $error("six-bit base not used");
  a_base_legacy: assert property (
    !$past(rst) && $past(ext_sys4_cpu_base) == 6'h00 |-> cpu_addr_hi ==
    {$past(ext_sys2_cpu_base), $past(st_r.tlock[3:0])} + {2'h0, $past(host_addr_hi)})
    else $error("legacy base wrong");
  a_vlock_block: assert property (
    st_r.tlock[ecb_pkg::TL_VLOCK] |=> vt_lock_rest && vt_lock_67)
    else $error("vertical lock not applied");
  a_hlock_block: assert property (
    vret_protect && !st_r.tlock[ecb_pkg::TL_HLOCK] |=> ht_lock_0_5 && !ht_lock_ext)
    else $error("horizontal protect wrong");
  a_refresh_over: assert property (
    st_r.misc1[ecb_pkg::M1_REFEN] |=> refresh_count == $past(st_r.misc1[1:0]))
    else $error("alternate refresh not applied");
  a_test_tristate: assert property (
    !st_r.s2[ecb_pkg::S2_TEST] |=> outputs_tristate)
    else $error("test mode did not tri-state");
  a_block_write_off: assert property (
    !st_r.s1[ecb_pkg::S1_BW] |=> !block_write_en)
    else $error("block write without support");
  a_key_relock: assert property (
    data_we && st_r.idx == ecb_pkg::IDX_KEY_LO &&
    (wdata & ecb_pkg::KEY_LO_MASK) != ecb_pkg::KEY_LO_VAL |=> !lo_open)
    else $error("bad key did not relock");
  // Read side covers the whole low range, key registers excepted
  a_locked_read_zero: assert property (
    !lo_open && in_lo(st_r.idx) && st_r.idx != ecb_pkg::IDX_KEY_LO &&
    st_r.idx != ecb_pkg::IDX_KEY_HI |=> rdata == 8'h00)
    else $error("locked register returned data");
  a_width_ext: assert property (
    ext_sys2_scr_width != 2'h0 |=> !screen_width_bit8)
    else $error("width bit 8 not ignored");

  c_lo_unlock: cover property (data_we && st_r.idx == ecb_pkg::IDX_KEY_LO ##1 lo_open);
  c_strap_key: cover property (strap_open && data_we && st_r.idx == ecb_pkg::IDX_STRAP1);
  c_base_override: cover property (ext_sys4_cpu_base != 6'h00 ##1 cpu_addr_hi != 6'h00);

endmodule
`default_nettype wire

// [ecb_host_model.sv]
// Host software model driving the indexed register port
`default_nettype none
module ecb_host_model (
  // Clock
  input wire logic clk,
  // Indexed port towards the bank
  output logic index_we,
  output logic data_we,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port from time zero
  initial begin
    index_we = 1'b0;
    data_we = 1'b0;
    wdata = 8'h00;
  end

  // Index cycle then data cycle; callers pass zero in reserved bits
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge clk);
    index_we <= 1'b1;
    wdata <= idx;
    @(posedge clk);
    index_we <= 1'b0;
    data_we <= 1'b1;
    wdata <= val;
    @(posedge clk);
    data_we <= 1'b0;
  endtask

  // Index cycle, then wait for the registered read path to settle
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    @(posedge clk);
    index_we <= 1'b1;
    wdata <= idx;
    @(posedge clk);
    index_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    val = rdata;
  endtask
endmodule
`default_nettype wire

// [test_ecb_bank.sv]
// Self-checking bench for the extended control bank
`default_nettype none
module test_ecb_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, index_we, data_we, host_addr13, block_write_req;
  logic [7:0] wdata, rdata, interlace_offset;
  logic [15:0] pixel_data_bus;
  logic vret_protect, std_refresh_count, transfer_pos_bit8, transfer_pos_select;
  logic [1:0] ext_sys2_cpu_base, ext_sys2_scr_width, refresh_count;
  logic [5:0] ext_sys4_cpu_base, cpu_addr_hi;
  logic [3:0] host_addr_hi, total_mem_mb, vram_mb;
  logic vt_lock_67, vt_lock_rest, ht_lock_0_5, ht_lock_ext, block_write_en;
  logic [2:0] page_mode_sel;
  logic outputs_tristate, internal_clocks, top_mem_32k, top_mem_64k, pixel_depth_select;
  logic fast_font_write, read_burst_disable, transfer_pos_use, interlace_select;
  logic enhanced_access_enable, screen_width_bit8, horizontal_count_double;
  logic [8:0] transfer_pos;
  int miscompares, n_compared;

  ecb_bank ecb_bank_i (.clk, .rst, .index_we, .data_we, .wdata, .rdata, .pixel_data_bus,
    .vret_protect, .std_refresh_count, .ext_sys2_cpu_base, .ext_sys2_scr_width,
    .ext_sys4_cpu_base, .transfer_pos_bit8, .transfer_pos_select, .host_addr_hi,
    .host_addr13, .block_write_req, .cpu_addr_hi, .vt_lock_67, .vt_lock_rest, .ht_lock_0_5,
    .ht_lock_ext, .page_mode_sel, .total_mem_mb, .vram_mb, .block_write_en,
    .outputs_tristate, .internal_clocks, .refresh_count, .top_mem_32k, .top_mem_64k,
    .pixel_depth_select, .fast_font_write, .read_burst_disable, .transfer_pos,
    .transfer_pos_use, .interlace_offset, .interlace_select, .enhanced_access_enable,
    .screen_width_bit8, .horizontal_count_double);

  ecb_host_model ecb_host_model_i (.clk, .index_we, .data_we, .wdata, .rdata);

  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    ecb_host_model_i.wr(i, d);
  endtask

  // Read one index and compare with the expected byte
  task automatic rdc(input logic [7:0] i, input logic [8:0] e);
    logic [7:0] r;
    ecb_host_model_i.rd(i, r);
    chk($sformatf("rdata at %h", i), e, {1'b0, r});
  endtask

  // Decoded outputs lag the register by a cycle; give them room
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic end_sim;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard far beyond the roughly 170 cycles the run needs
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end

  initial begin
    miscompares = 0;
    n_compared = 0;
    rst = 1'b1;
    pixel_data_bus = 16'h2AC9;
    {vret_protect, std_refresh_count, transfer_pos_bit8, transfer_pos_select} = 4'h0;
    {ext_sys2_cpu_base, ext_sys2_scr_width, ext_sys4_cpu_base} = 10'h000;
    host_addr_hi = 4'h4;
    host_addr13 = 1'b1;
    block_write_req = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    // Straps taken from the pixel bus
    chk("total_mem_mb", 9'h006, total_mem_mb);
    chk("vram_mb", 9'h002, vram_mb);
    chk("page_mode_sel", 9'h002, page_mode_sel);
    chk("block_write_en", 9'h001, block_write_en);
    chk("outputs_tristate", 9'h000, outputs_tristate);
    chk("internal_clocks", 9'h001, internal_clocks);
    rdc(8'h3A, 9'h000);
    rdc(8'h38, 9'h000);
    wr(8'h38, 8'h48);
    rdc(8'h36, 9'h0C9);
    rdc(8'h37, 9'h02A);
    // Misc controls, reserved bit 6 left zero
    wr(8'h3A, 8'hBE);
    settle;
    rdc(8'h3A, 9'h0BE);
    chk("refresh_count", 9'h002, refresh_count);
    chk("pixel_depth_select", 9'h001, pixel_depth_select);
    chk("read_burst_disable", 9'h001, read_burst_disable);
    chk("fast_font_write", 9'h001, fast_font_write);
    chk("top_mem_64k", 9'h001, top_mem_64k);
    chk("top_mem_32k", 9'h000, top_mem_32k);
    @(posedge clk);
    host_addr13 <= 1'b0;
    std_refresh_count <= 1'b1;
    wr(8'h3A, 8'h0A);
    settle;
    chk("top_mem_32k", 9'h001, top_mem_32k);
    chk("fast_font_write", 9'h000, fast_font_write);
    chk("refresh_count", 9'h001, refresh_count);
    chk("pixel_depth_select", 9'h000, pixel_depth_select);
    // Relock, attempt a write, reopen with don't-care bits set
    wr(8'h38, 8'h00);
    rdc(8'h3A, 9'h000);
    wr(8'h3A, 8'h00);
    wr(8'h38, 8'h7B);
    rdc(8'h3A, 9'h00A);
    // Strap writes need the A5 key; the low two bits of 36 never change
    wr(8'h39, 8'hA0);
    wr(8'h36, 8'h00);
    rdc(8'h36, 9'h0C9);
    wr(8'h39, 8'hA5);
    wr(8'h36, 8'h00);
    rdc(8'h36, 9'h001);
    wr(8'h37, 8'h60);
    settle;
    chk("total_mem_mb", 9'h002, total_mem_mb);
    chk("page_mode_sel", 9'h001, page_mode_sel);
    chk("block_write_en", 9'h000, block_write_en);
    chk("outputs_tristate", 9'h001, outputs_tristate);
    chk("internal_clocks", 9'h000, internal_clocks);
    chk("vram_mb", 9'h002, vram_mb);
    // Upper range controls
    wr(8'h39, 8'hA0);
    wr(8'h40, 8'h01);
    wr(8'h42, 8'h20);
    wr(8'h43, 8'h84);
    wr(8'h41, 8'h5A);
    settle;
    rdc(8'h42, 9'h020);
    rdc(8'h40, 9'h031);
    rdc(8'h41, 9'h05A);
    chk("enhanced_access_enable", 9'h001, enhanced_access_enable);
    chk("interlace_select", 9'h001, interlace_select);
    chk("screen_width_bit8", 9'h001, screen_width_bit8);
    chk("horizontal_count_double", 9'h001, horizontal_count_double);
    @(posedge clk);
    ext_sys2_scr_width <= 2'h1;
    settle;
    chk("screen_width_bit8", 9'h000, screen_width_bit8);
    wr(8'h39, 8'h00);
    rdc(8'h42, 9'h000);
    wr(8'h42, 8'h00);
    wr(8'h39, 8'hBF);
    rdc(8'h42, 9'h020);
    // Timing locks and window base
    wr(8'h35, 8'h35);
    settle;
    chk("vt_lock_rest", 9'h001, vt_lock_rest);
    chk("vt_lock_67", 9'h001, vt_lock_67);
    chk("ht_lock_0_5", 9'h001, ht_lock_0_5);
    chk("ht_lock_ext", 9'h001, ht_lock_ext);
    chk("cpu_addr_hi", 9'h009, cpu_addr_hi);
    @(posedge clk);
    vret_protect <= 1'b1;
    ext_sys2_cpu_base <= 2'h2;
    wr(8'h35, 8'h03);
    settle;
    chk("vt_lock_rest", 9'h000, vt_lock_rest);
    chk("vt_lock_67", 9'h001, vt_lock_67);
    chk("ht_lock_0_5", 9'h001, ht_lock_0_5);
    chk("ht_lock_ext", 9'h000, ht_lock_ext);
    chk("cpu_addr_hi", 9'h027, cpu_addr_hi);
    @(posedge clk);
    ext_sys4_cpu_base <= 6'h3F;
    settle;
    chk("cpu_addr_hi", 9'h003, cpu_addr_hi);
    // Transfer position and interlace offset
    @(posedge clk);
    transfer_pos_bit8 <= 1'b1;
    transfer_pos_select <= 1'b1;
    wr(8'h3B, 8'hA5);
    wr(8'h3C, 8'h12);
    settle;
    chk("transfer_pos", 9'h1A5, transfer_pos);
    chk("transfer_pos_use", 9'h001, transfer_pos_use);
    chk("interlace_offset", 9'h012, interlace_offset);
    end_sim;
  end
endmodule
`default_nettype wire
